// ==== dv/dev_id_err_assertions.sv ====
// port-level assertions for the identity and error history register bank
`timescale 1ns/10ps
module dev_id_err_assertions #(
    parameter logic [7:0] motor_code = dev_id_err_pkg::motor_both,
    parameter logic [15:0] profile_number = dev_id_err_pkg::profile_number_dflt
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:4] s_axi_bvalid) else $error("write answer missing");
    type_word_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 32'h0000_4000 |=> s_axi_rdata == {8'h00, motor_code, profile_number}
        && s_axi_rresp == dev_id_err_pkg::resp_okay) else $error("type word wrong");
    summary_shape_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 32'h0000_4004 |=> s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[6])
        else $error("summary reserved bits set");
    reset_state_a: assert property ($rose(aresetn) |->
        !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("outputs not idle after reset");
    cover property (s_axi_bvalid && s_axi_bresp == dev_id_err_pkg::resp_slverr);
    cover property (s_axi_rvalid && s_axi_rdata == dev_id_err_pkg::abort_access);
    cover property (irq);
endmodule
bind dev_id_err_regs dev_id_err_assertions #(
    .motor_code(motor_code),
    .profile_number(profile_number)
) i_dev_id_err_assertions (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);

// ==== dv/device_id_and_error_objects_test.sv ====
// self-checking bench for the identity and error history register bank
`timescale 1ns/10ps
module device_id_and_error_objects_test;
    localparam logic [15:0] cnt_i = dev_id_err_pkg::hist_count_idx;
    localparam logic [15:0] sum_i = dev_id_err_pkg::err_summary_idx;
    localparam logic [15:0] typ_i = dev_id_err_pkg::ctrl_type_idx;
    localparam logic [31:0] abort_v = dev_id_err_pkg::abort_access;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, err_code = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] fault_level = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, err_event = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    int mismatches = 0, checked = 0;
    dev_id_err_regs i_dev_id_err_regs (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_level, .err_event, .err_code, .irq
    );
    always #4 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // address and data held until each channel is taken
    task automatic wc(input string n, input logic [15:0] i, input logic [31:0] v, input bit bad);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= {14'h0, i, 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        chk(n, {30'h0, r}, bad ? dev_id_err_pkg::resp_slverr : dev_id_err_pkg::resp_okay);
    endtask
    task automatic rc(input string n, input logic [15:0] i, input logic [31:0] e, input bit bad);
        s_axi_araddr <= {14'h0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk(n, d, e);
        chk(n, {30'h0, r}, bad ? dev_id_err_pkg::resp_slverr : dev_id_err_pkg::resp_okay);
    endtask
    task automatic pulse(input int c);
        err_event <= 1'b1;
        err_code <= 32'(c);
        @(posedge aclk);
    endtask
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("type", typ_i, {8'h00, dev_id_err_pkg::motor_both, 16'h0001}, 0);
        rc("summary", sum_i, 32'h0, 0);
        rc("count", cnt_i, 32'h0, 0);
        for (int k = 1; k <= 8; k++) rc("empty", cnt_i + 16'(k), abort_v, 1);
        $display("reset test done");
        wc("type_wr", typ_i, 32'hffff_ffff, 1);
        wc("sum_wr", sum_i, 32'h0000_00ff, 1);
        wc("entry_wr", cnt_i + 16'h1, 32'h0000_0055, 1);
        rc("type_kept", typ_i, {8'h00, dev_id_err_pkg::motor_both, 16'h0001}, 0);
        rc("unmapped", 16'h1002, 32'h0, 1);
        $display("read-only test done");
        for (int b = 0; b < 9; b++) begin
            fault_level <= 8'(1 << b);
            repeat (3) @(posedge aclk);
            rc("class", sum_i, (b == 6) ? 32'h0 : 32'(1 << b) & 32'h0000_00ff, 0);
        end
        $display("summary test done");
        wc("irq_clr", dev_id_err_pkg::irq_status_idx, 32'h3, 0);
        wc("mask_off", dev_id_err_pkg::irq_mask_idx, 32'h0, 0);
        for (int i = 1; i <= 9; i++) pulse(32'h0000_0100 + i);
        err_event <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rc("count_sat", cnt_i, 32'h8, 0);
        for (int k = 1; k <= 8; k++) rc("entry", cnt_i + 16'(k), 32'(266 - k), 0);
        wc("mask_on", dev_id_err_pkg::irq_mask_idx, 32'h1, 0);
        chk("irq_on", {31'h0, irq}, 32'h1);
        rc("status", dev_id_err_pkg::irq_status_idx, 32'h1, 0);
        wc("irq_w1c", dev_id_err_pkg::irq_status_idx, 32'h1, 0);
        @(posedge aclk);
        chk("irq_off", {31'h0, irq}, 32'h0);
        $display("history test done");
        wc("count_nz", cnt_i, 32'h5, 1);
        rc("status_ref", dev_id_err_pkg::irq_status_idx, 32'h2, 0);
        rc("count_kept", cnt_i, 32'h8, 0);
        wc("count_zero", cnt_i, 32'h0, 0);
        rc("count_clr", cnt_i, 32'h0, 0);
        rc("entry_clr", cnt_i + 16'h1, abort_v, 1);
        pulse(32'h0000_0abc);
        err_event <= 1'b0;
        repeat (2) @(posedge aclk);
        rc("count_one", cnt_i, 32'h1, 0);
        rc("entry_new", cnt_i + 16'h1, 32'h0000_0abc, 0);
        $display("clear test done");
        close_out();
    end
endmodule

// ==== verilog/dev_id_err_pkg.sv ====
// constants for the controller identity and error history register bank
package dev_id_err_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] ctrl_type_idx = 16'h1000;
    localparam logic [15:0] err_summary_idx = 16'h1001;
    // history object has no printed index: chosen block at 0x1003
    localparam logic [15:0] hist_base_idx = 16'h1003;
    localparam logic [15:0] hist_count_idx = 16'h1003;
    localparam logic [15:0] irq_status_idx = 16'h1010;
    localparam logic [15:0] irq_mask_idx = 16'h1011;
    localparam logic [15:0] fault_clear_idx = 16'h1012;
    localparam int idx_lsb = 2;
    localparam int idx_w = 16;
    localparam int hist_sub_lsb = 10;
    localparam logic [5:0] hist_sub_base = 6'h0;

    localparam int hist_depth = 8;
    localparam logic [7:0] hist_max = 8'h08;
    localparam logic [7:0] hist_count_reset = 8'h00;
    localparam logic [31:0] hist_entry_reset = 32'h0000_0000;
    localparam logic [7:0] summary_reset = 8'h00;

    // motor type codes in bits 23..16
    localparam logic [7:0] motor_bldc = 8'h02;
    localparam logic [7:0] motor_stepper = 8'h04;
    localparam logic [7:0] motor_both = 8'h06;
    localparam int motor_lsb = 16;
    // drive profile number, low half
    localparam logic [15:0] profile_number_dflt = 16'h0001;

    // summary bit positions
    localparam int general_fault_bit = 0;
    localparam int current_fault_bit = 1;
    localparam int voltage_fault_bit = 2;
    localparam int temperature_fault_bit = 3;
    localparam int communication_fault_bit = 4;
    localparam int profile_fault_bit = 5;
    localparam int reserved_zero_bit = 6;
    localparam int maker_specific_fault_bit = 7;
    localparam logic [7:0] summary_mask = 8'hBF;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
    localparam logic [31:0] abort_access = 32'h0800_0024;

    // event bits of the interrupt status register
    localparam int irq_w = 2;
    localparam int irq_new_err = 0;
    localparam int irq_abort = 1;
endpackage

// ==== verilog/dev_id_err_regs.sv ====
// controller identity word, error summary and error history over axi4-lite
`timescale 1ns/10ps
// What this block does
// - a fixed 32-bit read-only controller type word is readable from reset.
// - bits 23..16 of that word hold the motor code 2, 4 or 6.
// - the low half of that word holds the supported drive profile number.
// - an 8-bit read-only error summary register reads zero after reset.
// - a summary bit follows its error condition, set while present, clear when gone.
// - summary bits are general, current, voltage, temperature, comms, profile, -, maker.
// - every new error also records its detailed code in the history.
// - the history holds up to eight 32-bit entries.
// - history sub-entry zero is an 8-bit writable count, zero after reset.
// - history entries one and up are read-only 32-bit words, zero after reset.
// - writes to read-only entries are refused and leave the value unchanged.
// - every preset value is loaded at reset.
// - every entry is 8, 16 or 32 bits wide.
// - a new error enters entry one and older ones shift down, the eighth dropped.
// - reading a history entry while none is recorded aborts with the access code.
// - writing zero to the count in a cycle with no new error restarts counting and clears the history.
module dev_id_err_regs #(
    parameter logic [7:0] motor_code = dev_id_err_pkg::motor_both,
    // arbitrary neutral value
    parameter logic [15:0] profile_number = dev_id_err_pkg::profile_number_dflt
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // error conditions and the detailed code of a newly occurring error
    input wire logic [7:0] fault_level,
    input wire logic err_event,
    input wire logic [31:0] err_code,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic [31:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] summary;
        logic [7:0] count;
        logic [dev_id_err_pkg::hist_depth-1:0][31:0] hist;
        logic [dev_id_err_pkg::irq_w-1:0] irq_status;
        logic [dev_id_err_pkg::irq_w-1:0] irq_mask;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [31:0] type_word;
    logic [15:0] ridx;
    logic [15:0] widx;
    logic [31:0] wmask;
    logic [31:0] wval;

    assign type_word = {8'h00, motor_code, profile_number};

    // per-lane write mask from the strobes
    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{s_q.wstrb[b]}};
        end
    endgenerate

    always_comb begin
        logic shift_in;
        logic ro_hit;
        logic read_abort;
        logic [5:0] sub;
        shift_in = 1'b0;
        ro_hit = 1'b0;
        read_abort = 1'b0;
        sub = 6'h0;
        s_d = s_q;
        ridx = s_axi_araddr[dev_id_err_pkg::idx_lsb +: dev_id_err_pkg::idx_w];
        widx = s_q.awaddr[dev_id_err_pkg::idx_lsb +: dev_id_err_pkg::idx_w];
        wval = s_q.wdata & wmask;

        // summary follows the live conditions; reserved bit forced low
        s_d.summary = fault_level & dev_id_err_pkg::summary_mask;

        // history push on a new error
        if (err_event) begin
            shift_in = 1'b1;
            for (int i = dev_id_err_pkg::hist_depth - 1; i > 0; i--) begin
                s_d.hist[i] = s_q.hist[i-1];
            end
            s_d.hist[0] = err_code;
            if (s_q.count < dev_id_err_pkg::hist_max) begin
                s_d.count = s_q.count + 8'h01;
            end
        end

        // write channel capture, either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.awaddr = s_axi_awaddr;
            s_d.aw_have = 1'b1;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.w_have = 1'b1;
            s_d.wready = 1'b0;
        end

        // perform write once both halves are held
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = dev_id_err_pkg::resp_okay;
            if (widx == dev_id_err_pkg::hist_count_idx) begin
                if (s_q.wstrb[0]) begin
                    if (wval[7:0] == 8'h00) begin
                        // clear wins only when no error arrives in this cycle
                        if (!shift_in) begin
                            s_d.count = dev_id_err_pkg::hist_count_reset;
                            for (int i = 0; i < dev_id_err_pkg::hist_depth; i++) begin
                                s_d.hist[i] = dev_id_err_pkg::hist_entry_reset;
                            end
                        end
                    end else begin
                        // nonzero write leaves the count alone
                        ro_hit = 1'b1;
                        s_d.bresp = dev_id_err_pkg::resp_slverr;
                    end
                end
            end else if (widx == dev_id_err_pkg::irq_status_idx) begin
                s_d.irq_status = s_d.irq_status & ~wval[dev_id_err_pkg::irq_w-1:0];
            end else if (widx == dev_id_err_pkg::irq_mask_idx) begin
                s_d.irq_mask = wval[dev_id_err_pkg::irq_w-1:0];
            end else begin
                ro_hit = 1'b1;
                s_d.bresp = dev_id_err_pkg::resp_slverr;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = dev_id_err_pkg::resp_okay;
            s_d.rdata = 32'h0000_0000;
            sub = 6'(ridx - dev_id_err_pkg::hist_base_idx);
            if (ridx == dev_id_err_pkg::ctrl_type_idx) begin
                s_d.rdata = type_word;
            end else if (ridx == dev_id_err_pkg::err_summary_idx) begin
                s_d.rdata = {24'h00_0000, s_q.summary};
            end else if (ridx == dev_id_err_pkg::hist_count_idx) begin
                s_d.rdata = {24'h00_0000, s_q.count};
            end else if (ridx > dev_id_err_pkg::hist_base_idx &&
                         ridx <= dev_id_err_pkg::hist_base_idx + 16'(dev_id_err_pkg::hist_depth)) begin
                if (s_q.count == dev_id_err_pkg::hist_count_reset) begin
                    read_abort = 1'b1;
                    s_d.rresp = dev_id_err_pkg::resp_slverr;
                    s_d.rdata = dev_id_err_pkg::abort_access;
                end else begin
                    s_d.rdata = s_q.hist[3'(sub - 6'h1)];
                end
            end else if (ridx == dev_id_err_pkg::irq_status_idx) begin
                s_d.rdata = 32'(s_q.irq_status);
            end else if (ridx == dev_id_err_pkg::irq_mask_idx) begin
                s_d.rdata = 32'(s_q.irq_mask);
            end else begin
                s_d.rresp = dev_id_err_pkg::resp_slverr;
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // sticky events, set wins over a same-cycle clear
        if (shift_in) begin
            s_d.irq_status[dev_id_err_pkg::irq_new_err] = 1'b1;
        end
        if (read_abort || ro_hit) begin
            s_d.irq_status[dev_id_err_pkg::irq_abort] = 1'b1;
        end
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);

        if (!aresetn) begin
            s_d = '0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
            s_d.arready = 1'b1;
            s_d.summary = dev_id_err_pkg::summary_reset;
            s_d.count = dev_id_err_pkg::hist_count_reset;
            for (int i = 0; i < dev_id_err_pkg::hist_depth; i++) begin
                s_d.hist[i] = dev_id_err_pkg::hist_entry_reset;
            end
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign irq = s_q.irq;
endmodule
